/* rtl/clk_mode_pkg.sv */
package clk_mode_pkg;
   // clocking modes chosen by straps
   typedef enum logic [1:0] {MODE_LOCAL, MODE_HOST, MODE_AGENT} clk_mode_t;
   // multiplier encoding: factor times two (2.5 -> 5)
   localparam int FACT_W = 5;
   localparam int CODE_W = 7;
   // register offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_FACTOR = 8'h04;
   localparam logic [7:0] OFF_TICK   = 8'h08;
   // reset values
   localparam logic [1:0] TICK_SEL_RST = 2'h0;
   // tick sub-steps per input period: ticks laid on a 140-step grid
   // (lcm of 4, 10, 14) so every documented fraction is exact
   localparam int TICK_GRID = 140;
   localparam logic [7:0] T_Q1   = 8'd35;   // 1/4
   localparam logic [7:0] T_HALF = 8'd70;   // 1/2
   localparam logic [7:0] T_Q3   = 8'd105;  // 3/4
   localparam logic [7:0] T_25_2 = 8'd42;   // 3/10
   localparam logic [7:0] T_25_4 = 8'd112;  // 8/10
   localparam logic [7:0] T_35_2 = 8'd40;   // 4/14
   localparam logic [7:0] T_35_4 = 8'd110;  // 11/14
endpackage : clk_mode_pkg

/* rtl/mode_table.sv */
`timescale 1ns/1ps
// combinational lookup from the seven-bit code to factors (all x2)
module mode_table
   import clk_mode_pkg::*;
(
   input  wire clk_mode_t           mode,
   input  wire logic                range_low,   // 1: 25-50 MHz tables
   input  wire logic [CODE_W-1:0]   code,
   output logic      [FACT_W-1:0]   cpm_x2,
   output logic      [FACT_W-1:0]   core_x2,
   output logic      [4:0]          pci_div_x2,
   output logic                     reserved
);
   // default local-bus table
   function automatic logic [9:0] dflt(input logic [2:0] c);
      case (c)
         3'h0: dflt = {5'd6, 5'd8};
         3'h1: dflt = {5'd6, 5'd10};
         3'h2: dflt = {5'd8, 5'd8};
         3'h3: dflt = {5'd8, 5'd10};
         3'h4: dflt = {5'd4, 5'd5};
         3'h5: dflt = {5'd4, 5'd6};
         3'h6: dflt = {5'd5, 5'd5};
         default: dflt = {5'd5, 5'd6};
      endcase
   endfunction : dflt

   // decode; unknown codes are treated as reserved
   always_comb
   begin
      cpm_x2     = 5'd0;
      core_x2    = 5'd0;
      pci_div_x2 = 5'd0;
      reserved   = 1'b0;
      case (mode)
         MODE_LOCAL:
         begin
            if (code[6:3] == 4'h0)
            begin
               {cpm_x2, core_x2} = dflt(code[2:0]);
            end
            else
            begin
               case (code)
                  7'h34: {cpm_x2, core_x2} = {5'd5, 5'd5};
                  7'h3b: {cpm_x2, core_x2} = {5'd6, 5'd6};
                  7'h30: {cpm_x2, core_x2} = {5'd4, 5'd7};
                  7'h31: {cpm_x2, core_x2} = {5'd4, 5'd8};
                  7'h35: {cpm_x2, core_x2} = {5'd5, 5'd6};
                  7'h42: {cpm_x2, core_x2} = {5'd7, 5'd7};
                  7'h43: {cpm_x2, core_x2} = {5'd7, 5'd8};
                  default: reserved = 1'b1;
               endcase
            end
         end
         MODE_HOST:
         begin
            case ({range_low, code})
               8'hc1: {cpm_x2, core_x2, pci_div_x2} = {5'd6, 5'd6, 5'd16};
               8'hc2: {cpm_x2, core_x2, pci_div_x2} = {5'd6, 5'd7, 5'd16};
               8'hc3: {cpm_x2, core_x2, pci_div_x2} = {5'd6, 5'd8, 5'd16};
               8'hd0: {cpm_x2, core_x2, pci_div_x2} = {5'd4, 5'd4, 5'd12};
               8'hd1: {cpm_x2, core_x2, pci_div_x2} = {5'd4, 5'd5, 5'd12};
               8'ha8: {cpm_x2, core_x2, pci_div_x2} = {5'd4, 5'd5, 5'd8};
               8'ha9: {cpm_x2, core_x2, pci_div_x2} = {5'd4, 5'd6, 5'd8};
               8'hb0: {cpm_x2, core_x2, pci_div_x2} = {5'd5, 5'd5, 5'd12};
               8'hb1: {cpm_x2, core_x2, pci_div_x2} = {5'd5, 5'd6, 5'd12};
               default: reserved = 1'b1;
            endcase
         end
         MODE_AGENT:
         begin
            case ({range_low, code})
               8'h21: {cpm_x2, core_x2} = {5'd6, 5'd6};
               8'h28: {cpm_x2, core_x2} = {5'd10, 5'd5};
               8'h39: {cpm_x2, core_x2} = {5'd6, 5'd5};
               8'hf0: {cpm_x2, core_x2} = {5'd10, 5'd5};
               8'hf1: {cpm_x2, core_x2} = {5'd10, 5'd6};
               default: reserved = 1'b1;
            endcase
         end
         default: reserved = 1'b1;
      endcase
   end
endmodule : mode_table

/* rtl/reset_clock_mode_decoder.sv */
`timescale 1ns/1ps
module reset_clock_mode_decoder
   import clk_mode_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        power_on_reset_in,       // high while power-on reset holds
   input  wire logic        host_port_select_strap,
   input  wire logic        agent_select_strap,
   input  wire logic        pci_range_strap,
   input  wire logic [2:0]  mode_strap_pins,
   input  wire logic [3:0]  config_word_mode_upper,
   input  wire logic [1:0]  pattern_tick_select,     // 0..3 picks T1..T4
   input  wire logic        pattern_out_in,
   input  wire logic        sdram_out_in,
   input  wire logic        chip_select_out_in,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic [1:0]       clock_mode,
   output logic [6:0]       mode_code,
   output logic [4:0]       comms_processor_clock_x2,
   output logic [4:0]       core_pll_x2,
   output logic [4:0]       pci_div_x2,
   output logic             mode_reserved,
   output logic             config_valid,
   output logic             pattern_out,
   output logic             sdram_out,
   output logic             chip_select_out
);
   // all state of the block
   typedef struct packed {
      clk_mode_t   mode;
      logic        range_low;
      logic [6:0]  code;
      logic [4:0]  comms_processor_clock;
      logic [4:0]  core;
      logic [4:0]  div;
      logic        rsvd;
      logic        valid;
      logic        in_por;      // power-on reset seen, waiting for release
      logic [7:0]  phase;       // sub-step within input period
      logic [1:0]  tick_sel;    // software copy of the tick select
      logic        use_sw_sel;
      logic        pat;
      logic        sdr;
      logic        gcs;
      logic        dph;         // data phase pending
      logic        dph_wr;
      logic [7:0]  dph_addr;
      logic [31:0] rdata;
   } state_t;

   state_t st_reg;              // registered state
   state_t st_next;             // next state

   clk_mode_t        sel_mode;  // strap-chosen mode
   logic [6:0]       sel_code;  // live code
   logic [4:0]       tab_cpm;
   logic [4:0]       tab_core;
   logic [4:0]       tab_div;
   logic             tab_rsvd;
   logic [7:0]       t2;
   logic [7:0]       t3;
   logic [7:0]       t4;
   logic [1:0]       eff_sel;   // tick select in use
   logic             on_tick;   // selected tick arrives this step

   // straps pick the clocking mode
   always_comb
   begin
      if (host_port_select_strap)
      begin
         sel_mode = MODE_LOCAL;
      end
      else
      begin
         sel_mode = agent_select_strap ? MODE_AGENT : MODE_HOST;
      end
      sel_code = {config_word_mode_upper, mode_strap_pins};
   end

   mode_table u_table (
      .mode       (sel_mode),
      .range_low  (pci_range_strap),
      .code       (sel_code),
      .cpm_x2     (tab_cpm),
      .core_x2    (tab_core),
      .pci_div_x2 (tab_div),
      .reserved   (tab_rsvd)
   );

   tick_gen u_tick (
      .core_x2 (st_reg.core),
      .t2_pos  (t2),
      .t3_pos  (t3),
      .t4_pos  (t4)
   );

   // tick select: pins unless software has taken over
   always_comb
   begin
      eff_sel = st_reg.use_sw_sel ? st_reg.tick_sel : pattern_tick_select;
      case (eff_sel)
         2'd0: on_tick = (st_reg.phase == 8'd0);
         2'd1: on_tick = (st_reg.phase == t2);
         2'd2: on_tick = (st_reg.phase == t3);
         default: on_tick = (st_reg.phase == t4);
      endcase
   end

   // next-state logic
   always_comb
   begin
      st_next = st_reg;
      // latch configuration only while power-on reset is held
      if (power_on_reset_in)
      begin
         st_next.in_por    = 1'b1;
         st_next.valid     = 1'b0;
         st_next.mode      = sel_mode;
         st_next.range_low = pci_range_strap;
         st_next.code      = sel_code;
         st_next.rsvd      = tab_rsvd;
         // a reserved code programs nothing
         st_next.comms_processor_clock       = tab_rsvd ? 5'd0 : tab_cpm;
         st_next.core      = tab_rsvd ? 5'd0 : tab_core;
         st_next.div       = tab_rsvd ? 5'd0 : tab_div;
      end
      else if (st_reg.in_por)
      begin
         // release: configuration frozen from here on
         st_next.in_por = 1'b0;
         st_next.valid  = ~st_reg.rsvd;
      end
      // sub-period phase: the grid stands for one reference period,
      // bus clocks run at reference rate so no divider is applied
      st_next.phase = (st_reg.phase == 8'(TICK_GRID - 1)) ? 8'd0
                      : 8'(st_reg.phase + 8'd1);
      // pattern machine updates on its chosen tick
      if (on_tick)
      begin
         st_next.pat = pattern_out_in;
      end
      // sdram and chip-select only at the period start (rising edge)
      if (st_reg.phase == 8'd0)
      begin
         st_next.sdr = sdram_out_in;
         st_next.gcs = chip_select_out_in;
      end
      // ahb-lite slave: zero-wait, always okay
      if (st_reg.dph && st_reg.dph_wr && st_reg.dph_addr == OFF_TICK)
      begin
         st_next.tick_sel   = hwdata[1:0];
         st_next.use_sw_sel = hwdata[4];
      end
      if (hready)
      begin
         st_next.dph      = hsel && htrans[1];
         st_next.dph_wr   = hwrite;
         st_next.dph_addr = haddr[7:0];
         case (haddr[7:0])
            OFF_STATUS: st_next.rdata = {22'h0, st_reg.valid, st_reg.rsvd,
                                         st_reg.code, 1'b0};
            OFF_FACTOR: st_next.rdata = {17'h0, st_reg.div, st_reg.core, st_reg.comms_processor_clock};
            OFF_TICK:   st_next.rdata = {27'h0, st_reg.use_sw_sel, 2'h0,
                                         st_reg.tick_sel};
            default:    st_next.rdata = 32'h0;   // unmapped reads as zero
         endcase
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // outputs straight from flops, hreadyout and hresp tied off
   always_comb
   begin
      hrdata                   = st_reg.rdata;
      hreadyout                = 1'b1;
      hresp                    = 1'b0;
      clock_mode               = st_reg.mode;
      mode_code                = st_reg.code;
      comms_processor_clock_x2 = st_reg.comms_processor_clock;
      core_pll_x2              = st_reg.core;
      pci_div_x2               = st_reg.div;
      mode_reserved            = st_reg.rsvd;
      config_valid             = st_reg.valid;
      pattern_out              = st_reg.pat;
      sdram_out                = st_reg.sdr;
      chip_select_out          = st_reg.gcs;
   end
endmodule : reset_clock_mode_decoder

/* rtl/tick_gen.sv */
`timescale 1ns/1ps
// memory-controller tick positions within one input period, grid of 140
module tick_gen
   import clk_mode_pkg::*;
(
   input  wire logic [FACT_W-1:0] core_x2,
   output logic      [7:0]        t2_pos,
   output logic      [7:0]        t3_pos,
   output logic      [7:0]        t4_pos
);
   // half-integer ratios get their own spacing
   always_comb
   begin
      t3_pos = T_HALF;
      case (core_x2)
         5'd5:
         begin
            t2_pos = T_25_2;
            t4_pos = T_25_4;
         end
         5'd7:
         begin
            t2_pos = T_35_2;
            t4_pos = T_35_4;
         end
         default:
         begin
            t2_pos = T_Q1;
            t4_pos = T_Q3;
         end
      endcase
   end
endmodule : tick_gen

/* verification/reset_clock_mode_decoder_props.sv */
`timescale 1ns/1ps
// checker on the decoder ports
module reset_clock_mode_decoder_props
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       power_on_reset_in,
   input wire logic       host_port_select_strap,
   input wire logic       agent_select_strap,
   input wire logic [2:0] mode_strap_pins,
   input wire logic [3:0] config_word_mode_upper,
   input wire logic [1:0] clock_mode,
   input wire logic [6:0] mode_code,
   input wire logic [4:0] comms_processor_clock_x2,
   input wire logic [4:0] core_pll_x2,
   input wire logic [4:0] pci_div_x2,
   input wire logic       mode_reserved,
   input wire logic       config_valid
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // end of a power-on reset
   sequence s_por_end;
      $fell(power_on_reset_in);
   endsequence
   sequence s_quiet;
      !power_on_reset_in [*2];
   endsequence
   property p_code;
      power_on_reset_in |=>
         mode_code == {$past(config_word_mode_upper), $past(mode_strap_pins)};
   endproperty
   property p_local;
      power_on_reset_in && host_port_select_strap |=> clock_mode == 2'h0;
   endproperty
   // agent strap 1 gives agent (2), 0 gives host (1)
   property p_host;
      power_on_reset_in && !host_port_select_strap |=>
         clock_mode == {$past(agent_select_strap), !$past(agent_select_strap)};
   endproperty
   property p_hold;
      s_quiet |-> $stable(mode_code) && $stable(core_pll_x2)
         && $stable(comms_processor_clock_x2) && $stable(pci_div_x2);
   endproperty
   property p_reserved;
      mode_reserved |-> comms_processor_clock_x2 == 5'h0 && core_pll_x2 == 5'h0;
   endproperty
   // the second cycle leaves room for the one-cycle rise
   property p_valid;
      s_por_end |-> ##2 (config_valid == !mode_reserved);
   endproperty
   property p_div;
      clock_mode != 2'h1 |-> pci_div_x2 == 5'h0;
   endproperty
   property p_code34;
      power_on_reset_in && host_port_select_strap && config_word_mode_upper == 4'h6
         && mode_strap_pins == 3'h4 |=> comms_processor_clock_x2 == 5'h5 && core_pll_x2 == 5'h5;
   endproperty
   property p_def0;
      power_on_reset_in && host_port_select_strap && config_word_mode_upper == 4'h0
         && mode_strap_pins == 3'h0 |=> comms_processor_clock_x2 == 5'h6 && core_pll_x2 == 5'h8;
   endproperty
   a_code: assert property (p_code) else $error("mode code not taken");
   a_local: assert property (p_local) else $error("local mode missed");
   a_host: assert property (p_host) else $error("host or agent wrong");
   a_hold: assert property (p_hold) else $error("config moved");
   a_reserved: assert property (p_reserved) else $error("reserved programmed");
   a_valid: assert property (p_valid) else $error("valid flag wrong");
   a_div: assert property (p_div) else $error("divider outside host");
   a_code34: assert property (p_code34) else $error("code 34 factors");
   a_def0: assert property (p_def0) else $error("default 0 factors");
endmodule : reset_clock_mode_decoder_props

/* verification/strap_source.sv */
`timescale 1ns/1ps
// board side: strap levels and power-on reset for the decoder
module strap_source
#(
   parameter int POR_CYC = 3        // reset length in hclk cycles
)
(
   input  wire logic       hclk,
   input  wire logic       go,      // pulse: apply cfg through a reset
   input  wire logic [9:0] cfg,     // {host, agent, range, upper, pins}
   output logic            por,
   output logic [9:0]      pins,
   output logic            busy
);
   int cnt = 0;                     // cycles of reset still to run
   initial
   begin
      por = 1'b0;
      pins = 10'h0;
      busy = 1'b0;
   end
   // straps are shared with bus pins, so once reset ends they carry
   // other traffic that changes every cycle
   always @(posedge hclk)
   begin
      if (go)
      begin
         pins <= cfg;               // code and frequency are the board's choice
         por <= 1'b1;
         busy <= 1'b1;
         cnt <= POR_CYC;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
      else if (cnt == 1)
      begin
         por <= 1'b0;
         cnt <= 0;
      end
      else
      begin
         pins <= ~pins;
         busy <= 1'b0;
      end
   end
endmodule : strap_source

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        hclk = 1'b0, hresetn = 1'b0, d = 1'b0, go = 1'b0;
   logic        power_on_reset_in, host_port_select_strap, agent_select_strap;
   logic        pci_range_strap, hready, hreadyout, hresp, busy;
   logic        hsel = 1'b0, hwrite = 1'b0;
   logic [2:0]  mode_strap_pins, hsize = 3'h2;
   logic [3:0]  config_word_mode_upper;
   logic [1:0]  pattern_tick_select = 2'h0, htrans = 2'h0, clock_mode;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [6:0]  mode_code;
   logic [4:0]  comms_processor_clock_x2, core_pll_x2, pci_div_x2;
   logic        mode_reserved, config_valid, pattern_out, sdram_out, chip_select_out;
   logic [9:0]  cfg = 10'h0, strap;
   int          err_total = 0, n_compared = 0, cyc = 0;
   // default-mode factors x2, code 0 in the low slice
   localparam logic [39:0] CP = {5'd5, 5'd5, 5'd4, 5'd4, 5'd8, 5'd8, 5'd6, 5'd6};
   localparam logic [39:0] CO = {5'd6, 5'd5, 5'd6, 5'd5, 5'd10, 5'd8, 5'd10, 5'd8};
   assign hready = hreadyout;       // one slave drives the bus ready
   assign {host_port_select_strap, agent_select_strap, pci_range_strap,
           config_word_mode_upper, mode_strap_pins} = strap;
   initial forever #12.5 hclk = ~hclk;
   strap_source #(.POR_CYC(3)) u_src (.hclk, .go, .cfg, .por(power_on_reset_in),
      .pins(strap), .busy);
   reset_clock_mode_decoder DUT (.hclk, .hresetn, .power_on_reset_in,
      .host_port_select_strap, .agent_select_strap, .pci_range_strap, .mode_strap_pins,
      .config_word_mode_upper, .pattern_tick_select, .pattern_out_in(d), .sdram_out_in(d),
      .chip_select_out_in(d), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .clock_mode, .mode_code, .comms_processor_clock_x2,
      .core_pll_x2, .pci_div_x2, .mode_reserved, .config_valid, .pattern_out, .sdram_out,
      .chip_select_out);
   task complete_run();
      if (err_total == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one power-on reset through the board model
   task apply(input logic [9:0] c);
      @(posedge hclk);
      cfg <= c;
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      do @(posedge hclk); while (busy !== 1'b0);
      repeat (3) @(posedge hclk);
   endtask : apply
   task expect_cfg(input logic [9:0] c, input logic [1:0] m, input logic [4:0] cp,
                   input logic [4:0] co, input logic [4:0] dv, input logic rs);
      apply(c);
      chk(32'(clock_mode), 32'(m));
      chk(32'(mode_code), 32'(c[6:0]));
      chk(32'(comms_processor_clock_x2), 32'(cp));
      chk(32'(core_pll_x2), 32'(co));
      chk(32'(pci_div_x2), 32'(dv));
      chk(32'({mode_reserved, config_valid}), 32'({rs, !rs}));
   endtask : expect_cfg
   // single AHB-Lite word transfer, waits on the ready
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task wait_sd(input logic v);
      do @(posedge hclk); while (sdram_out !== v);
      @(posedge hclk);
   endtask : wait_sd
   // cycles from a phase-0 edge until the pattern output follows the input
   task tick_at(input logic [6:0] code, input logic [1:0] sel, input int p);
      int n;
      pattern_tick_select <= sel;
      apply({3'b100, code});
      d <= 1'b0;
      wait_sd(1'b0);
      d <= 1'b1;
      wait_sd(1'b1);
      // land the input change on the next phase-0 edge itself
      repeat (138) @(posedge hclk);
      d <= 1'b0;
      n = 0;
      do
      begin
         @(posedge hclk);
         #1;
         n++;
      end while (pattern_out !== 1'b0 && n < 300);
      chk(32'(n), 32'(p));
      chk(32'({sdram_out, chip_select_out}), (p < 140) ? 32'h3 : 32'h0);
   endtask : tick_at
   task t_local();
      for (int i = 0; i < 8; i++)
         expect_cfg({7'h40, 3'(i)}, 2'h0, CP[i*5 +: 5], CO[i*5 +: 5], 5'h0, 1'b0);
      expect_cfg(10'h234, 2'h0, 5'h5, 5'h5, 5'h0, 1'b0);
      expect_cfg(10'h23b, 2'h0, 5'h6, 5'h6, 5'h0, 1'b0);
      expect_cfg(10'h233, 2'h0, 5'h0, 5'h0, 5'h0, 1'b1);
   endtask : t_local
   task t_host();
      expect_cfg(10'h0a8, 2'h1, 5'h4, 5'h5, 5'h8, 1'b0);
      expect_cfg(10'h0c1, 2'h1, 5'h6, 5'h6, 5'h10, 1'b0);
      apply(10'h121);
      chk(32'({clock_mode, pci_div_x2}), 32'h40);
   endtask : t_host
   // straps keep moving after reset; registers show the held decode
   task t_regs();
      apply(10'h234);
      repeat (20) @(posedge hclk);
      chk(32'(mode_code), 32'h34);
      ahb(1'b1, 8'h00, 32'hffffffff);
      ahb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h268);
      ahb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'ha5);
      chk(32'(hresp), 32'h0);
      ahb(1'b0, 8'h0c, 32'h0);
      chk(rd, 32'h0);
   endtask : t_regs
   task t_ticks();
      tick_at(7'h00, 2'h1, 35);
      tick_at(7'h04, 2'h1, 42);
      tick_at(7'h30, 2'h1, 40);
      tick_at(7'h04, 2'h3, 112);
      tick_at(7'h30, 2'h3, 110);
      tick_at(7'h00, 2'h2, 70);
      tick_at(7'h00, 2'h0, 140);
      ahb(1'b1, 8'h08, 32'h13);
      ahb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h13);
      tick_at(7'h04, 2'h1, 112);
      ahb(1'b1, 8'h08, 32'h0);
   endtask : t_ticks
   // cut a hung run short
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         complete_run();
      end
   end
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      t_local();
      t_host();
      t_regs();
      t_ticks();
      complete_run();
   end
endmodule : tb
bind reset_clock_mode_decoder reset_clock_mode_decoder_props u_props (.hclk, .hresetn,
   .power_on_reset_in, .host_port_select_strap, .agent_select_strap, .mode_strap_pins,
   .config_word_mode_upper, .clock_mode, .mode_code, .comms_processor_clock_x2,
   .core_pll_x2, .pci_div_x2, .mode_reserved, .config_valid);
